// ===== pvcir_pkg.sv
// shared constants for the phy vendor config and event register pair
package pvcir_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  // management register addresses
  localparam logic [4:0] VENDOR_CFG_ADDR = 5'h10;
  localparam logic [4:0] EVENT_EN_STS_ADDR = 5'h11;
  localparam logic [15:0] VENDOR_CFG_RESET = 16'h0140;
  localparam logic [15:0] EVENT_EN_STS_RESET = 16'h0000;
  // vendor config field positions
  localparam int RX_CLOCK_GATING_BIT = 0;
  localparam int CODING_BYPASS_BIT = 1;
  localparam int RSVD_LO_BIT = 2;
  localparam int RSVD_HI_BIT = 3;
  localparam int RX_POLARITY_BIT = 4;
  localparam int AUTOPOL_DIS_BIT = 5;
  localparam logic [15:0] VENDOR_UPPER_MASK = 16'hFFC0;
  // event flag positions, enables sit EVENT_EN_SHIFT higher
  localparam int EVENT_CNT = 8;
  localparam int EVENT_EN_SHIFT = 8;
  localparam int NEG_DONE_BIT = 0;
  localparam int REMOTE_FAULT_BIT = 1;
  localparam int LINK_DROP_BIT = 2;
  localparam int PARTNER_ACK_BIT = 3;
  localparam int PARDET_FAULT_BIT = 4;
  localparam int PAGE_RCVD_BIT = 5;
  localparam int RX_ERROR_BIT = 6;
  localparam int JABBER_BIT = 7;
  // controller's own register map
  localparam int CTL_ADDR_W = 3;
  localparam logic [2:0] CTL_TARGET_ADDR = 3'h0;
  localparam logic [2:0] CTL_WDATA_ADDR = 3'h1;
  localparam logic [2:0] CTL_CMD_ADDR = 3'h2;
  localparam logic [2:0] CTL_RDATA_ADDR = 3'h3;
  localparam logic [2:0] CTL_IRQ_STS_ADDR = 3'h4;
  localparam logic [2:0] CTL_IRQ_MASK_ADDR = 3'h5;
  localparam logic [2:0] CTL_STATUS_ADDR = 3'h6;
  localparam int CMD_WRITE_BIT = 0;
  localparam int CMD_READ_BIT = 1;
  localparam int CMD_POLL_BIT = 2;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_PHY_BIT = 1;
  localparam int IRQ_EVENT_BIT = 2;
  localparam int CTL_IRQ_W = 3;
  typedef enum logic [1:0] {
    PVCIR_IDLE = 2'b00,
    PVCIR_ACCESS = 2'b01,
    PVCIR_CAPTURE = 2'b11
  } pvcir_state_t;
endpackage

// ===== pvcir_mgmt_if.sv
// management link between the phy register pair and its controller
`timescale 1ns/1ns
interface pvcir_mgmt_if;
  logic [4:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic phyIrq;
  modport dev (input addr, input wdata, input wr, input rd, output rdata, output phyIrq);
  modport ctl (output addr, output wdata, output wr, output rd, input rdata, input phyIrq);
endinterface

// ===== pvcir_device.sv
// phy vendor config register and event enable/status register
//
// Functional notes
// [RULE_01] bit 5 disables automatic receive polarity correction
// [RULE_02] auto mode inverts on reversed 10Base-T polarity
// [RULE_03] auto mode: bit 4 read-only, shows inversion
// [RULE_04] disabled auto: bit 4 writable, forces inversion
// [RULE_05] bit 1 bypasses coding layer in 100TX; the code bypasses only while anegEnabled is low
// [RULE_06] bit 0 stops idle receive clock 100TX
// [RULE_07] loopback forces clock gating off
// [RULE_08] bits 3:2 reserved, read zero
// [RULE_09] event sets its flag bit 0..7
// [RULE_10] reading event register clears flags
// [RULE_11] enable bits route flags to interrupt
// [RULE_12] fixed flag order, enables eight higher
// [RULE_13] controller may poll event register
// [RULE_14] link flag only on good-to-failed
// [RULE_15] event during read keeps flag set
`timescale 1ns/1ns
module pvcir_device
  import pvcir_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  pvcir_mgmt_if.dev mgmt,
  input wire logic tenBaseMode,
  input wire logic hundredTxMode,
  input wire logic anegEnabled,
  input wire logic loopbackCtrl,
  input wire logic polarityCheck,
  input wire logic polarityReversed,
  input wire logic rxNoData,
  input wire logic jabberEvt,
  input wire logic rxErrorEvt,
  input wire logic pageRcvdEvt,
  input wire logic pardetFaultEvt,
  input wire logic partnerAckEvt,
  input wire logic linkGood,
  input wire logic remoteFaultEvt,
  input wire logic negDoneEvt,
  output logic rxPolarityInvert,
  output logic codingLayerBypass,
  output logic rxClockStop,
  output logic macRawIrqStatus
);
  import pvcir_pkg::*;

  logic [15:0] upperCfg_q;
  logic autopolDisable_q;
  logic forcedInvert_q;
  logic autoInvert_q;
  logic codingBypass_q;
  logic rxClockGating_q;
  logic [7:0] eventEn_q;
  logic [7:0] eventFlag_q;
  logic [7:0] eventHit;
  logic linkGood_q;
  logic [15:0] rdata_q;
  logic cfgWr;
  logic evtWr;
  logic evtRd;
  logic invertNow;
  logic [15:0] cfgView;

  function automatic logic hit(input logic [4:0] a, input logic [4:0] target);
    hit = (a == target);
  endfunction

  assign cfgWr = mgmt.wr && hit(mgmt.addr, VENDOR_CFG_ADDR);
  assign evtWr = mgmt.wr && hit(mgmt.addr, EVENT_EN_STS_ADDR);
  assign evtRd = mgmt.rd && hit(mgmt.addr, EVENT_EN_STS_ADDR);

  // upper bits kept as plain storage
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      upperCfg_q <= VENDOR_CFG_RESET & VENDOR_UPPER_MASK;
    end else if (cfgWr) begin
      upperCfg_q <= mgmt.wdata & VENDOR_UPPER_MASK;
    end
  end

  // vendor mode bits
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      autopolDisable_q <= VENDOR_CFG_RESET[AUTOPOL_DIS_BIT];
      codingBypass_q <= VENDOR_CFG_RESET[CODING_BYPASS_BIT];
      rxClockGating_q <= VENDOR_CFG_RESET[RX_CLOCK_GATING_BIT];
    end else if (cfgWr) begin
      autopolDisable_q <= mgmt.wdata[AUTOPOL_DIS_BIT]; // RULE_01
      codingBypass_q <= mgmt.wdata[CODING_BYPASS_BIT]; // RULE_05
      rxClockGating_q <= mgmt.wdata[RX_CLOCK_GATING_BIT]; // RULE_06
    end
  end

  // forced polarity only takes writes while auto-polarity is off
  // a write that sets the disable bit cannot force in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      forcedInvert_q <= VENDOR_CFG_RESET[RX_POLARITY_BIT];
    end else if (cfgWr && autopolDisable_q) begin
      forcedInvert_q <= mgmt.wdata[RX_POLARITY_BIT]; // RULE_04
    end
  end

  // auto-polarity follows the 10Base-T check in 10Base-T mode, with or without negotiation
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      autoInvert_q <= 1'b0;
    end else if (autopolDisable_q) begin
      autoInvert_q <= 1'b0; // RULE_01
    end else if (polarityCheck && tenBaseMode) begin
      autoInvert_q <= polarityReversed; // RULE_02
    end
  end

  assign invertNow = autopolDisable_q ? forcedInvert_q : autoInvert_q; // RULE_03 RULE_04

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rxPolarityInvert <= 1'b0;
    end else begin
      rxPolarityInvert <= invertNow;
    end
  end

  // bypass only meaningful with fixed 100 Mb/s operation
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      codingLayerBypass <= 1'b0;
    end else begin
      codingLayerBypass <= codingBypass_q && hundredTxMode && !anegEnabled; // RULE_05
    end
  end

  // loopback overrides the power saving clock stop
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rxClockStop <= 1'b0;
    end else begin
      rxClockStop <= rxClockGating_q && hundredTxMode && rxNoData // RULE_06
                     && !loopbackCtrl; // RULE_07
    end
  end

  // previous link level; reset low so no drop is seen at start
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      linkGood_q <= 1'b0;
    end else begin
      linkGood_q <= linkGood;
    end
  end

  always_comb begin
    eventHit = '0;
    eventHit[JABBER_BIT] = jabberEvt; // RULE_12
    eventHit[RX_ERROR_BIT] = rxErrorEvt;
    eventHit[PAGE_RCVD_BIT] = pageRcvdEvt;
    eventHit[PARDET_FAULT_BIT] = pardetFaultEvt;
    eventHit[PARTNER_ACK_BIT] = partnerAckEvt;
    eventHit[LINK_DROP_BIT] = linkGood_q && !linkGood; // RULE_14
    eventHit[REMOTE_FAULT_BIT] = remoteFaultEvt;
    eventHit[NEG_DONE_BIT] = negDoneEvt;
  end

  // read clears, but a same-cycle event keeps its flag
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      eventFlag_q <= EVENT_EN_STS_RESET[EVENT_CNT-1:0];
    end else if (evtRd) begin
      eventFlag_q <= eventHit; // RULE_10 RULE_15
    end else begin
      eventFlag_q <= eventFlag_q | eventHit; // RULE_09
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      eventEn_q <= EVENT_EN_STS_RESET[DATA_W-1:EVENT_EN_SHIFT];
    end else if (evtWr) begin
      eventEn_q <= mgmt.wdata[DATA_W-1:EVENT_EN_SHIFT]; // RULE_12
    end
  end

  assign macRawIrqStatus = |(eventFlag_q & eventEn_q); // RULE_11
  assign mgmt.phyIrq = macRawIrqStatus;

  // config word as software sees it
  always_comb begin
    cfgView = upperCfg_q;
    cfgView[AUTOPOL_DIS_BIT] = autopolDisable_q;
    cfgView[RX_POLARITY_BIT] = invertNow; // RULE_03
    cfgView[RSVD_HI_BIT:RSVD_LO_BIT] = 2'h0; // RULE_08
    cfgView[CODING_BYPASS_BIT] = codingBypass_q;
    cfgView[RX_CLOCK_GATING_BIT] = rxClockGating_q;
  end

  // read data stands the cycle after the read strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= '0;
    end else if (mgmt.rd) begin
      rdata_q <= '0;
      if (hit(mgmt.addr, VENDOR_CFG_ADDR)) begin
        rdata_q <= cfgView;
      end else if (evtRd) begin
        rdata_q <= {eventEn_q, eventFlag_q}; // RULE_13
      end
    end
  end

  assign mgmt.rdata = rdata_q;
endmodule

// ===== pvcir_ctrl.sv
// management controller: software registers driving the phy link
`timescale 1ns/1ns
module pvcir_ctrl
  import pvcir_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  pvcir_mgmt_if.ctl mgmt,
  input wire logic [pvcir_pkg::CTL_ADDR_W-1:0] swAddr,
  input wire logic [15:0] swWdata,
  input wire logic swWr,
  input wire logic swRd,
  output logic [15:0] swRdata,
  output logic irq
);
  import pvcir_pkg::*;

  pvcir_state_t state_q;
  logic [4:0] target_q;
  logic [15:0] wdata_q;
  logic opWrite_q;
  logic poll_q;
  logic pollOp_q;
  logic [15:0] result_q;
  logic [CTL_IRQ_W-1:0] irqSts_q;
  logic [CTL_IRQ_W-1:0] irqMask_q;
  logic [CTL_IRQ_W-1:0] irqSet;
  logic goWrite;
  logic goRead;
  logic goPoll;

  function automatic logic sel(input logic [2:0] a, input logic [2:0] r);
    sel = (a == r);
  endfunction

  assign goWrite = swWr && sel(swAddr, CTL_CMD_ADDR) && swWdata[CMD_WRITE_BIT];
  assign goRead = swWr && sel(swAddr, CTL_CMD_ADDR) && swWdata[CMD_READ_BIT];
  // polling fetches the event register whenever the phy raises its line
  assign goPoll = poll_q && mgmt.phyIrq; // RULE_13

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      target_q <= '0;
      wdata_q <= '0;
      poll_q <= 1'b0;
      irqMask_q <= '0;
    end else if (swWr) begin
      if (sel(swAddr, CTL_TARGET_ADDR)) target_q <= swWdata[ADDR_W-1:0];
      if (sel(swAddr, CTL_WDATA_ADDR)) wdata_q <= swWdata;
      if (sel(swAddr, CTL_CMD_ADDR)) poll_q <= swWdata[CMD_POLL_BIT];
      if (sel(swAddr, CTL_IRQ_MASK_ADDR)) irqMask_q <= swWdata[CTL_IRQ_W-1:0];
    end
  end

  // commands arriving while busy are dropped
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= PVCIR_IDLE;
      opWrite_q <= 1'b0;
      pollOp_q <= 1'b0;
    end else begin
      unique case (state_q)
        PVCIR_IDLE: begin
          if (goWrite || goRead || goPoll) begin
            state_q <= PVCIR_ACCESS;
            opWrite_q <= goWrite;
            pollOp_q <= !goWrite && !goRead;
          end
        end
        PVCIR_ACCESS: state_q <= opWrite_q ? PVCIR_IDLE : PVCIR_CAPTURE;
        PVCIR_CAPTURE: state_q <= PVCIR_IDLE;
        default: state_q <= PVCIR_IDLE;
      endcase
    end
  end

  assign mgmt.addr = pollOp_q ? EVENT_EN_STS_ADDR : target_q;
  assign mgmt.wdata = wdata_q;
  assign mgmt.wr = (state_q == PVCIR_ACCESS) && opWrite_q;
  assign mgmt.rd = (state_q == PVCIR_ACCESS) && !opWrite_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      result_q <= '0;
    end else if (state_q == PVCIR_CAPTURE) begin
      result_q <= mgmt.rdata;
    end
  end

  always_comb begin
    irqSet = '0;
    irqSet[IRQ_DONE_BIT] = (state_q == PVCIR_CAPTURE) || mgmt.wr;
    irqSet[IRQ_PHY_BIT] = mgmt.phyIrq;
    irqSet[IRQ_EVENT_BIT] = (state_q == PVCIR_CAPTURE) && pollOp_q
                            && |mgmt.rdata[EVENT_CNT-1:0];
  end

  // write one to clear; a new event wins over the clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irqSts_q <= '0;
    end else if (swWr && sel(swAddr, CTL_IRQ_STS_ADDR)) begin
      irqSts_q <= (irqSts_q & ~swWdata[CTL_IRQ_W-1:0]) | irqSet;
    end else begin
      irqSts_q <= irqSts_q | irqSet;
    end
  end

  assign irq = |(irqSts_q & irqMask_q);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      swRdata <= '0;
    end else if (swRd) begin
      unique case (swAddr)
        CTL_TARGET_ADDR: swRdata <= {11'h000, target_q};
        CTL_WDATA_ADDR: swRdata <= wdata_q;
        CTL_CMD_ADDR: swRdata <= {13'h0000, poll_q, 2'h0};
        CTL_RDATA_ADDR: swRdata <= result_q;
        CTL_IRQ_STS_ADDR: swRdata <= {13'h0000, irqSts_q};
        CTL_IRQ_MASK_ADDR: swRdata <= {13'h0000, irqMask_q};
        CTL_STATUS_ADDR: swRdata <= {15'h0000, state_q != PVCIR_IDLE};
        default: swRdata <= '0;
      endcase
    end else begin
      swRdata <= '0;
    end
  end
endmodule

// ===== pvcir_link_checker.sv
// assertions on the management link between the register pair and its controller
`timescale 1ns/1ns
module pvcir_link_checker
  import pvcir_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [4:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  input wire logic phyIrq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_no_dual_strobe: assert property (!(wr && rd))
    else $error("write and read strobes together");
  a_wr_one_cycle: assert property (wr |=> !wr)
    else $error("write strobe longer than one cycle");
  a_rd_one_cycle: assert property (rd |=> !rd)
    else $error("read strobe longer than one cycle");
  a_rdata_holds: assert property (!rd |=> $stable(rdata))
    else $error("read data changed without a read");
  a_rsvd_read_zero: assert property (
    rd && addr == VENDOR_CFG_ADDR |=> rdata[3:2] == 2'b00)
    else $error("reserved config bits not zero");
  a_unmapped_zero: assert property (rd && addr != VENDOR_CFG_ADDR && addr != EVENT_EN_STS_ADDR
    |=> rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_irq_no_enable: assert property (
    wr && addr == EVENT_EN_STS_ADDR && wdata[15:8] == 8'h00 |=> !phyIrq)
    else $error("interrupt with all enables off");
  a_irq_has_cause: assert property (
    rd && addr == EVENT_EN_STS_ADDR && phyIrq |=> (rdata[15:8] & rdata[7:0]) != 8'h00)
    else $error("interrupt without enabled flag");
  a_irq_quiet_read: assert property (
    rd && addr == EVENT_EN_STS_ADDR && !phyIrq |=> (rdata[15:8] & rdata[7:0]) == 8'h00)
    else $error("enabled flag read while interrupt low");
  c_cfg_write: cover property (wr && addr == VENDOR_CFG_ADDR);
  c_irq_read: cover property (rd && addr == EVENT_EN_STS_ADDR && phyIrq);
  c_unmapped_read: cover property (rd && addr == 5'h05);
endmodule

// ===== phy_vendor_config_and_irq_regs_tb.sv
// self-checking bench joining the register pair and its controller
`timescale 1ns/1ns
module phy_vendor_config_and_irq_regs_tb;
  import pvcir_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] swAddr = 3'h0;
  logic [15:0] swWdata = 16'h0000;
  logic swWr = 1'b0;
  logic swRd = 1'b0;
  logic tenB = 1'b0, hTx = 1'b0, aneg = 1'b0, lpbk = 1'b0, pChk = 1'b0, pRev = 1'b0;
  logic noData = 1'b0;
  logic linkGood = 1'b1;
  logic [7:0] evt = 8'h00;
  logic [15:0] swRdata, v;
  logic irq, rxPol, bypass, clkStop, rawIrq;
  int n_fail = 0;
  int n_checks = 0;
  pvcir_mgmt_if mgmt();
  pvcir_device u_pvcir_device (.clk(clk), .nrst(nrst), .mgmt(mgmt), .tenBaseMode(tenB),
    .hundredTxMode(hTx), .anegEnabled(aneg), .loopbackCtrl(lpbk), .polarityCheck(pChk),
    .polarityReversed(pRev), .rxNoData(noData), .jabberEvt(evt[7]), .rxErrorEvt(evt[6]),
    .pageRcvdEvt(evt[5]), .pardetFaultEvt(evt[4]), .partnerAckEvt(evt[3]),
    .linkGood(linkGood), .remoteFaultEvt(evt[1]), .negDoneEvt(evt[0]),
    .rxPolarityInvert(rxPol), .codingLayerBypass(bypass), .rxClockStop(clkStop),
    .macRawIrqStatus(rawIrq));
  pvcir_ctrl u_pvcir_ctrl (.clk(clk), .nrst(nrst), .mgmt(mgmt), .swAddr(swAddr),
    .swWdata(swWdata), .swWr(swWr), .swRd(swRd), .swRdata(swRdata), .irq(irq));
  pvcir_link_checker u_pvcir_link_checker (.clk(clk), .nrst(nrst), .addr(mgmt.addr),
    .wdata(mgmt.wdata), .wr(mgmt.wr), .rd(mgmt.rd), .rdata(mgmt.rdata), .phyIrq(mgmt.phyIrq));
  always #50 clk = ~clk;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic swW(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    swAddr <= a;
    swWdata <= d;
    swWr <= 1'b1;
    @(posedge clk);
    swWr <= 1'b0;
  endtask
  task automatic swR(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk);
    swAddr <= a;
    swRd <= 1'b1;
    @(posedge clk);
    swRd <= 1'b0;
    #1 d = swRdata;
  endtask
  task automatic waitIdle();
    logic [15:0] s;
    for (int i = 0; i < 20; i++) begin
      swR(CTL_STATUS_ADDR, s);
      if (s[0] === 1'b0) return;
    end
    check(s, 16'h0000);
  endtask
  task automatic phyW(input logic [4:0] a, input logic [15:0] d);
    swW(CTL_TARGET_ADDR, {11'h000, a});
    swW(CTL_WDATA_ADDR, d);
    swW(CTL_CMD_ADDR, 16'h0001);
    waitIdle();
  endtask
  task automatic phyR(input logic [4:0] a, output logic [15:0] d);
    swW(CTL_TARGET_ADDR, {11'h000, a});
    swW(CTL_CMD_ADDR, 16'h0002);
    waitIdle();
    swR(CTL_RDATA_ADDR, d);
  endtask
  task automatic t_reset();
    phyR(VENDOR_CFG_ADDR, v);
    check(v, VENDOR_CFG_RESET);
    phyR(EVENT_EN_STS_ADDR, v);
    check(v, EVENT_EN_STS_RESET);
    swR(3'h7, v);
    check(v, 16'h0000);
  endtask
  task automatic t_irq();
    swW(CTL_IRQ_STS_ADDR, 16'h0007);
    swW(CTL_IRQ_MASK_ADDR, 16'h0007);
    phyR(5'h05, v);
    check(v, 16'h0000);
    swR(CTL_IRQ_STS_ADDR, v);
    check(v & 16'h0001, 16'h0001);
    check({15'h0000, irq}, 16'h0001);
    swW(CTL_IRQ_MASK_ADDR, 16'h0006);
    @(negedge clk);
    check({15'h0000, irq}, 16'h0000);
    swW(CTL_IRQ_MASK_ADDR, 16'h0007);
    swW(CTL_IRQ_STS_ADDR, 16'h0001);
    @(negedge clk);
    check({15'h0000, irq}, 16'h0000);
  endtask
  task automatic t_vendor();
    @(posedge clk);
    hTx <= 1'b1;
    noData <= 1'b1;
    phyW(VENDOR_CFG_ADDR, 16'h00FF);
    // second write forces polarity now that auto mode is off
    phyW(VENDOR_CFG_ADDR, 16'h00FF);
    phyR(VENDOR_CFG_ADDR, v);
    check(v, 16'h00F3);
    check({13'h0000, rxPol, bypass, clkStop}, 16'h0007);
    @(posedge clk);
    lpbk <= 1'b1;
    aneg <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check({14'h0000, bypass, clkStop}, 16'h0000);
    @(posedge clk);
    lpbk <= 1'b0;
    aneg <= 1'b0;
    phyW(VENDOR_CFG_ADDR, 16'h0020);
    @(negedge clk);
    check({15'h0000, rxPol}, 16'h0000);
    phyW(VENDOR_CFG_ADDR, 16'h0000);
    phyW(VENDOR_CFG_ADDR, 16'h0010);
    phyR(VENDOR_CFG_ADDR, v);
    check(v, 16'h0000);
    @(posedge clk);
    tenB <= 1'b1;
    pChk <= 1'b1;
    pRev <= 1'b1;
    @(posedge clk);
    pChk <= 1'b0;
    phyR(VENDOR_CFG_ADDR, v);
    check(v, 16'h0010);
    check({15'h0000, rxPol}, 16'h0001);
    phyW(VENDOR_CFG_ADDR, 16'h0020);
    phyR(VENDOR_CFG_ADDR, v);
    check(v, 16'h0020);
    check({15'h0000, rxPol}, 16'h0000);
  endtask
  task automatic t_events();
    phyW(EVENT_EN_STS_ADDR, 16'h0100);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      if (i == 2) linkGood <= 1'b0;
      else evt <= 8'h01 << i;
      @(posedge clk);
      evt <= 8'h00;
      @(posedge clk);
      @(negedge clk);
      check({15'h0000, rawIrq}, {15'h0000, i == 0});
      phyR(EVENT_EN_STS_ADDR, v);
      check(v, 16'h0100 | (16'h0001 << i));
    end
    @(posedge clk);
    linkGood <= 1'b1;
    repeat (2) @(posedge clk);
    phyR(EVENT_EN_STS_ADDR, v);
    check(v, 16'h0100);
    swW(CTL_TARGET_ADDR, {11'h000, EVENT_EN_STS_ADDR});
    swW(CTL_CMD_ADDR, 16'h0002);
    evt[0] <= 1'b1;
    @(posedge clk);
    evt[0] <= 1'b0;
    waitIdle();
    swR(CTL_RDATA_ADDR, v);
    check(v, 16'h0100);
    phyR(EVENT_EN_STS_ADDR, v);
    check(v, 16'h0101);
  endtask
  task automatic t_poll();
    phyW(EVENT_EN_STS_ADDR, 16'h8000);
    swW(CTL_IRQ_STS_ADDR, 16'h0007);
    swW(CTL_CMD_ADDR, 16'h0004);
    @(posedge clk);
    evt[7] <= 1'b1;
    @(posedge clk);
    evt[7] <= 1'b0;
    waitIdle();
    swR(CTL_IRQ_STS_ADDR, v);
    check(v & 16'h0004, 16'h0004);
    swR(CTL_RDATA_ADDR, v);
    check(v, 16'h8080);
    check({15'h0000, rawIrq}, 16'h0000);
    phyW(EVENT_EN_STS_ADDR, 16'h0000);
    check({15'h0000, rawIrq}, 16'h0000);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_irq();
    t_vendor();
    t_events();
    t_poll();
    print_verdict();
  end
  initial begin
    #(3000 * 100);
    n_fail++;
    print_verdict();
  end
endmodule
